// *** nvm_cycle.sv ***
`timescale 1ns/10ps
`include "nvm_params.svh"

module nvm_cycle #(
  parameter int ACCESS_CYCLES = (`NVM_ACCESS_NS * `NVM_CLK_MHZ + 999) / 1000,
  parameter int PRECHARGE_CYCLES = (`NVM_PRECHARGE_NS * `NVM_CLK_MHZ + 999) / 1000
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire nvm_pkg::nvm_req_s i_req,
  output logic o_done,
  output logic [15:0] o_rdata,
  output nvm_pkg::nvm_pins_s o_mem,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_dq_oe
);

  typedef enum logic [2:0] {
    CY_IDLE = 3'b000,
    CY_SETUP = 3'b001,
    CY_ACTIVE = 3'b011,
    CY_RELEASE = 3'b010,
    CY_PRECHARGE = 3'b110
  } nvm_cyc_state_e;

  nvm_cyc_state_e state;
  logic [7:0] cnt;
  logic wr;
  wire cnt_zero = (cnt == 8'h00);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= CY_IDLE;
      cnt <= 8'h00;
      wr <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
      o_mem <= '{addr: 17'h00000, sel_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, ub_n: 1'b1, lb_n: 1'b1};
      o_dq <= 16'h0000;
      o_dq_oe <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      case (state)
        CY_IDLE:
        begin
          if (i_start)
          begin
            // address, lanes, strobe and data settle before select falls
            o_mem.addr <= i_req.addr;
            o_mem.ub_n <= i_req.ub_n;
            o_mem.lb_n <= i_req.lb_n;
            o_mem.we_n <= ~i_req.write;
            o_dq <= i_req.data;
            o_dq_oe <= i_req.write;
            wr <= i_req.write;
            state <= CY_SETUP;
          end
        end
        CY_SETUP:
        begin
          // select-controlled cycles only: one write pulse per access
          o_mem.sel_n <= 1'b0;
          o_mem.oe_n <= wr;
          cnt <= 8'(ACCESS_CYCLES - 1);
          state <= CY_ACTIVE;
        end
        CY_ACTIVE:
        begin
          if (cnt_zero)
          begin
            // select rise ends the write; data still held at this edge
            if (!wr)
            begin
              o_rdata <= i_dq;
            end
            o_mem.sel_n <= 1'b1;
            o_mem.oe_n <= 1'b1;
            state <= CY_RELEASE;
          end
          else
          begin
            cnt <= cnt - 8'h01;
          end
        end
        CY_RELEASE:
        begin
          o_mem.we_n <= 1'b1;
          o_dq_oe <= 1'b0;
          cnt <= 8'(PRECHARGE_CYCLES - 1);
          state <= CY_PRECHARGE;
        end
        CY_PRECHARGE:
        begin
          // select stays high the whole time
          if (cnt_zero)
          begin
            o_done <= 1'b1;
            state <= CY_IDLE;
          end
          else
          begin
            cnt <= cnt - 8'h01;
          end
        end
        default:
        begin
          state <= CY_IDLE;
        end
      endcase
    end
  end

endmodule

// *** nvm_host.sv ***
// Functional notes
// - new page needs select falling or change of address bits 16 to 2.
// - host meets access time and holds write data stable before terminating edge.
// - host pulses write strobe separately for every individual write.
// - host keeps select high at least precharge time before next access.
// - protect change: six fixed reads, three fixed writes, then read at zero.
// - with select low at sequence start, host first accesses address zero.
// - host never holds select low longer than 10 microseconds.
`timescale 1ns/10ps
`include "nvm_params.svh"

module nvm_host #(
  parameter int ACCESS_CYCLES = (`NVM_ACCESS_NS * `NVM_CLK_MHZ + 999) / 1000,
  parameter int PRECHARGE_CYCLES = (`NVM_PRECHARGE_NS * `NVM_CLK_MHZ + 999) / 1000
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output nvm_pkg::nvm_pins_s o_mem,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_dq_oe
);

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ISSUE = 2'b01,
    M_WAIT = 2'b11
  } nvm_main_state_e;

  nvm_main_state_e state;
  logic [3:0] step;
  logic [1:0] op;
  logic lane_lo;
  logic lane_hi;
  logic [16:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [7:0] prot_reg;
  logic done_flag;
  logic rd_ack;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [31:0] rd_value;
  logic [16:0] seq_addr;
  nvm_pkg::nvm_req_s req;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // bus decode
  wire busy = (state != M_IDLE);
  wire sel_ctrl = (i_avs_address == `NVM_REG_CTRL);
  wire sel_addr = (i_avs_address == `NVM_REG_ADDR);
  wire sel_wdata = (i_avs_address == `NVM_REG_WDATA);
  wire sel_prot = (i_avs_address == `NVM_REG_PROT);
  // reads wait one cycle for registered data; commands stall while busy
  assign o_avs_waitrequest = (i_avs_read & ~rd_ack) | (i_avs_write & sel_ctrl & busy);
  wire wr_take = i_avs_write & ~o_avs_waitrequest;
  wire start_cmd = wr_take & sel_ctrl & i_avs_byteenable[0] & i_avs_writedata[`NVM_CTRL_START];
  wire is_prot = (op == nvm_pkg::NVM_OP_PROTECT);
  wire last_access = ~is_prot | (step == `NVM_SEQ_LAST);
  wire cyc_start = (state == M_ISSUE);

  // protect sequence table; step 0 is a lead-in access at zero
  always_comb
  begin
    case (step)
      4'h1: seq_addr = `NVM_SEQ_A1;
      4'h2: seq_addr = `NVM_SEQ_A2;
      4'h3: seq_addr = `NVM_SEQ_A3;
      4'h4: seq_addr = `NVM_SEQ_A4;
      4'h5: seq_addr = `NVM_SEQ_A5;
      4'h6: seq_addr = `NVM_SEQ_A6;
      4'h7: seq_addr = `NVM_SEQ_A2;
      4'h8: seq_addr = `NVM_SEQ_A4;
      4'h9: seq_addr = `NVM_SEQ_W3;
      default: seq_addr = `NVM_ADDR_ZERO;
    endcase
  end

  wire seq_write = (step >= `NVM_SEQ_FIRST_WR) & (step <= `NVM_SEQ_LAST_WR);
  // protection byte then its complement on the low lane
  wire [7:0] seq_byte = (step == `NVM_SEQ_FIRST_WR) ? prot_reg :
                        (step == (`NVM_SEQ_FIRST_WR + 4'h1)) ? ~prot_reg : 8'h00;
  wire plain_write = (op == nvm_pkg::NVM_OP_WRITE);

  assign req.write = is_prot ? seq_write : plain_write;
  assign req.addr = is_prot ? seq_addr : addr_reg;
  assign req.data = is_prot ? {8'h00, seq_byte} : wdata_reg;
  // single accesses use the lanes software picked
  assign req.ub_n = is_prot ? 1'b0 : ~lane_hi;
  assign req.lb_n = is_prot ? 1'b0 : ~lane_lo;

  always_comb
  begin
    rd_value = 32'h00000000;
    case (i_avs_address)
      `NVM_REG_CTRL:
      begin
        rd_value[`NVM_CTRL_OP_MSB:`NVM_CTRL_OP_LSB] = op;
        rd_value[`NVM_CTRL_LANE_LO] = lane_lo;
        rd_value[`NVM_CTRL_LANE_HI] = lane_hi;
      end
      `NVM_REG_ADDR: rd_value[16:0] = addr_reg;
      `NVM_REG_WDATA: rd_value[15:0] = wdata_reg;
      `NVM_REG_RDATA: rd_value[15:0] = cyc_rdata;
      `NVM_REG_STATUS:
      begin
        rd_value[`NVM_STAT_BUSY] = busy;
        rd_value[`NVM_STAT_DONE] = done_flag;
        rd_value[`NVM_STAT_STEP_MSB:`NVM_STAT_STEP_LSB] = step;
      end
      `NVM_REG_PROT: rd_value[7:0] = prot_reg;
      default: rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rd_ack <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end
    else
    begin
      rd_ack <= i_avs_read & ~rd_ack;
      if (i_avs_read & ~rd_ack)
      begin
        o_avs_readdata <= rd_value;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      op <= nvm_pkg::NVM_OP_READ;
      lane_lo <= 1'b1;
      lane_hi <= 1'b1;
      addr_reg <= 17'h00000;
      wdata_reg <= 16'h0000;
      prot_reg <= 8'h00;
    end
    else if (wr_take)
    begin
      if (sel_ctrl & i_avs_byteenable[0])
      begin
        op <= i_avs_writedata[`NVM_CTRL_OP_MSB:`NVM_CTRL_OP_LSB];
        lane_lo <= i_avs_writedata[`NVM_CTRL_LANE_LO];
        lane_hi <= i_avs_writedata[`NVM_CTRL_LANE_HI];
      end
      if (sel_addr)
      begin
        addr_reg <= 17'(be_merge({15'h0000, addr_reg}, i_avs_writedata, i_avs_byteenable));
      end
      if (sel_wdata)
      begin
        wdata_reg <= 16'(be_merge({16'h0000, wdata_reg}, i_avs_writedata, i_avs_byteenable));
      end
      if (sel_prot & i_avs_byteenable[0])
      begin
        prot_reg <= i_avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= M_IDLE;
      step <= 4'h0;
      done_flag <= 1'b0;
    end
    else
    begin
      // completion beats a clear in the same cycle
      if (state == M_WAIT && cyc_done && last_access)
      begin
        done_flag <= 1'b1;
      end
      else if (start_cmd)
      begin
        done_flag <= 1'b0;
      end
      case (state)
        M_IDLE:
        begin
          if (start_cmd)
          begin
            step <= 4'h0;
            state <= M_ISSUE;
          end
        end
        M_ISSUE:
        begin
          state <= M_WAIT;
        end
        M_WAIT:
        begin
          if (cyc_done)
          begin
            if (last_access)
            begin
              state <= M_IDLE;
            end
            else
            begin
              // no other access may slip between sequence steps
              step <= step + 4'h1;
              state <= M_ISSUE;
            end
          end
        end
        default:
        begin
          state <= M_IDLE;
        end
      endcase
    end
  end

  nvm_cycle #(
    .ACCESS_CYCLES(ACCESS_CYCLES),
    .PRECHARGE_CYCLES(PRECHARGE_CYCLES)
  ) u_cycle (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(cyc_start),
    .i_req(req),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_mem(o_mem),
    .i_dq(i_dq),
    .o_dq(o_dq),
    .o_dq_oe(o_dq_oe)
  );

endmodule

// *** nvm_host_monitor.sv ***
`timescale 1ns/10ps
module nvm_host_monitor #(
  parameter int ACCESS_CYCLES = 2,
  parameter int PRECHARGE_CYCLES = 2
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_avs_read,
  input wire logic o_avs_waitrequest,
  input wire nvm_pkg::nvm_pins_s o_mem,
  input wire logic [15:0] o_dq,
  input wire logic o_dq_oe
);
  logic [7:0] lo_cnt;
  logic [7:0] hi_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // hi_cnt saturates so long idle stretches never wrap into a false short precharge
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      lo_cnt <= 8'h00;
      hi_cnt <= 8'h00;
    end
    else
    begin
      lo_cnt <= o_mem.sel_n ? 8'h00 : lo_cnt + 8'h01;
      hi_cnt <= !o_mem.sel_n ? 8'h00 : (hi_cnt == 8'hff ? hi_cnt : hi_cnt + 8'h01);
    end
  end
  sel_len_a: assert property ($rose(o_mem.sel_n) |-> lo_cnt == ACCESS_CYCLES)
    else $error("select low time differs from access length");
  sel_max_a: assert property (!o_mem.sel_n |-> lo_cnt < ACCESS_CYCLES)
    else $error("select held low too long");
  precharge_a: assert property ($fell(o_mem.sel_n) |-> hi_cnt > PRECHARGE_CYCLES)
    else $error("select high too short before access");
  addr_hold_a: assert property (!o_mem.sel_n |-> $stable(o_mem.addr))
    else $error("address moved while selected");
  wdata_hold_a: assert property (!o_mem.sel_n && !o_mem.we_n |-> $stable(o_dq) && o_dq_oe)
    else $error("write data not held during write");
  wend_data_a: assert property ($rose(o_mem.sel_n) && !o_mem.we_n |-> o_dq_oe)
    else $error("write data released before ending edge");
  strobe_fall_a: assert property ($fell(o_mem.we_n) |-> o_mem.sel_n)
    else $error("write strobe fell while selected");
  strobe_rise_a: assert property ($rose(o_mem.sel_n) && !o_mem.we_n |=> o_mem.we_n)
    else $error("write strobe not released after write");
  out_drive_a: assert property (!o_mem.oe_n |-> o_mem.we_n && !o_dq_oe)
    else $error("output enable low during write or host drive");
  read_wait_a: assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("register read latency wrong");
endmodule

bind nvm_host nvm_host_monitor #(
  .ACCESS_CYCLES(ACCESS_CYCLES),
  .PRECHARGE_CYCLES(PRECHARGE_CYCLES)
) i_monitor (
  .i_clk(i_clk),
  .i_rstn(i_rstn),
  .i_avs_read(i_avs_read),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_mem(o_mem),
  .o_dq(o_dq),
  .o_dq_oe(o_dq_oe)
);

// *** nvm_mem_model.sv ***
`timescale 1ns/10ps
module nvm_mem_model #(
  parameter int ACC_NS = 60
)
(
  input wire nvm_pkg::nvm_pins_s i_mem,
  input wire logic [15:0] i_host_dq,
  input wire logic i_host_oe,
  output logic [15:0] o_dq
);
  logic [15:0] mem [0:131071];
  logic [7:0] prot = 8'h00;
  logic [16:0] lat_addr = 17'h0;
  logic wr_open = 1'b0;
  logic valid = 1'b0;
  logic [7:0] pend = 8'h00;
  int step = 0;
  logic [16:0] seq [0:5] = '{17'h12555, 17'h1daaa, 17'h01333, 17'h0eccc, 17'h000ff, 17'h1ff00};
  wire [15:0] rd = mem[lat_addr];
  wire drv = !i_mem.sel_n && !i_mem.oe_n && i_mem.we_n && valid;
  // undriven lanes show the inverse so a stray sample cannot match
  assign o_dq = i_host_oe ? i_host_dq : {(drv && !i_mem.ub_n) ? rd[15:8] : ~rd[15:8],
    (drv && !i_mem.lb_n) ? rd[7:0] : ~rd[7:0]};
  initial foreach (mem[i]) mem[i] = 16'h0;
  always @(negedge i_mem.sel_n)
  begin
    lat_addr = i_mem.addr;
    wr_open = !i_mem.we_n;
    valid = 1'b0;
    valid <= #(ACC_NS) 1'b1;
    if (step < 6)
      step = (i_mem.we_n && i_mem.addr == seq[step]) ? step + 1 : 0;
    else if (i_mem.we_n)
      step = 0;
  end
  always @(i_mem.addr) if (!i_mem.sel_n) lat_addr = i_mem.addr;
  always @(negedge i_mem.we_n)
    if (!i_mem.sel_n)
    begin
      wr_open = 1'b1;
      lat_addr[1:0] = i_mem.addr[1:0];
    end
  always @(posedge i_mem.we_n or posedge i_mem.sel_n)
    if (wr_open)
    begin
      wr_open = 1'b0;
      if (step == 6)
      begin
        pend = o_dq[7:0];
        step = 7;
      end
      else if (step == 7)
      begin
        if (o_dq[7:0] == ~pend) prot = pend;
        step = 0;
      end
      else if (!prot[lat_addr[16:14]])
      begin
        if (!i_mem.ub_n) mem[lat_addr][15:8] = o_dq[15:8];
        if (!i_mem.lb_n) mem[lat_addr][7:0] = o_dq[7:0];
      end
    end
endmodule

// *** nvm_params.svh ***
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH

// clock and timing
`define NVM_CLK_MHZ 20
`define NVM_ACCESS_NS 100
`define NVM_PRECHARGE_NS 100
`define NVM_SEL_LOW_MAX_US 10

// register word indexes on the avalon slave
`define NVM_REG_CTRL 3'h0
`define NVM_REG_ADDR 3'h1
`define NVM_REG_WDATA 3'h2
`define NVM_REG_RDATA 3'h3
`define NVM_REG_STATUS 3'h4
`define NVM_REG_PROT 3'h5

// control fields
`define NVM_CTRL_START 0
`define NVM_CTRL_OP_LSB 1
`define NVM_CTRL_OP_MSB 2
`define NVM_CTRL_LANE_LO 4
`define NVM_CTRL_LANE_HI 5

// status fields
`define NVM_STAT_BUSY 0
`define NVM_STAT_DONE 1
`define NVM_STAT_STEP_LSB 8
`define NVM_STAT_STEP_MSB 11

// protect sequence addresses and step numbers
`define NVM_ADDR_ZERO 17'h00000
`define NVM_SEQ_A1 17'h12555
`define NVM_SEQ_A2 17'h1daaa
`define NVM_SEQ_A3 17'h01333
`define NVM_SEQ_A4 17'h0eccc
`define NVM_SEQ_A5 17'h000ff
`define NVM_SEQ_A6 17'h1ff00
`define NVM_SEQ_W3 17'h0ff00
`define NVM_SEQ_FIRST_WR 4'h7
`define NVM_SEQ_LAST_WR 4'h9
`define NVM_SEQ_LAST 4'ha

`endif

// *** nvm_pkg.sv ***
package nvm_pkg;

  typedef enum logic [1:0] {
    NVM_OP_READ = 2'h0,
    NVM_OP_WRITE = 2'h1,
    NVM_OP_PROTECT = 2'h2
  } nvm_op_e;

  // pins driven toward the memory, all strobes active low
  typedef struct packed {
    logic [16:0] addr;
    logic sel_n;
    logic we_n;
    logic oe_n;
    logic ub_n;
    logic lb_n;
  } nvm_pins_s;

  // one bus access handed to the cycle engine
  typedef struct packed {
    logic write;
    logic [16:0] addr;
    logic [15:0] data;
    logic ub_n;
    logic lb_n;
  } nvm_req_s;

endpackage

// *** tb_nvm_host.sv ***
`timescale 1ns/10ps
`include "nvm_params.svh"
module tb_nvm_host;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] address = 3'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [3:0] be_sel = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  nvm_pkg::nvm_pins_s pins;
  logic [15:0] dq;
  logic [15:0] host_dq;
  logic host_oe;
  logic rd_chk = 1'b0;
  logic [31:0] exp_q [$];
  logic [31:0] rv;
  logic [16:0] ad [0:7];
  logic [15:0] dat [0:7];
  logic [15:0] nd;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  initial forever #25 i_clk = ~i_clk;
  nvm_host #(.ACCESS_CYCLES(2), .PRECHARGE_CYCLES(2)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
    .i_avs_writedata(writedata), .i_avs_byteenable(byteenable), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitrequest), .o_mem(pins), .i_dq(dq), .o_dq(host_dq),
    .o_dq_oe(host_oe));
  nvm_mem_model #(.ACC_NS(90)) i_mem (.i_mem(pins), .i_host_dq(host_dq), .i_host_oe(host_oe),
    .o_dq(dq));
  task automatic compare(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got)
    begin
      num_errors++;
      $display("ERROR %0t exp %h got %h", $time, exp, got);
    end
  endtask
  always @(posedge i_clk)
    if (read && !waitrequest && rd_chk)
      compare(exp_q.pop_front(), readdata);
  task automatic close_out();
    $display("compared %0d mismatched %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd,
    input logic chk, input logic [31:0] exp);
    @(posedge i_clk);
    address <= a;
    writedata <= wd;
    byteenable <= be_sel;
    write <= wr;
    read <= !wr;
    rd_chk <= chk;
    if (chk) exp_q.push_back(exp);
    @(posedge i_clk);
    while (waitrequest) @(posedge i_clk);
    rv = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic mem_op(input logic [1:0] op, input logic [16:0] a, input logic [15:0] wd,
    input logic [1:0] ln);
    bus(1'b1, `NVM_REG_ADDR, {15'h0, a}, 1'b0, 32'h0);
    bus(1'b1, `NVM_REG_WDATA, {16'h0, wd}, 1'b0, 32'h0);
    bus(1'b1, `NVM_REG_CTRL, {26'h0, ln, 1'b0, op, 1'b1}, 1'b0, 32'h0);
    rv = 32'h0;
    // an unknown done bit must keep polling, not end it
    while (rv[`NVM_STAT_DONE] !== 1'b1) bus(1'b0, `NVM_REG_STATUS, 32'h0, 1'b0, 32'h0);
  endtask
  task automatic protect(input logic [7:0] pb);
    bus(1'b1, `NVM_REG_PROT, {24'h0, pb}, 1'b0, 32'h0);
    mem_op(nvm_pkg::NVM_OP_PROTECT, 17'h0, 16'h0, 2'h3);
    bus(1'b0, `NVM_REG_RDATA, 32'h0, 1'b1, 32'h0);
  endtask
  task automatic sweep(input logic [7:0] pb);
    for (int s = 0; s < 8; s++)
    begin
      nd = 16'($urandom());
      mem_op(nvm_pkg::NVM_OP_WRITE, ad[s], nd, 2'h3);
      if (!pb[s]) dat[s] = nd;
      mem_op(nvm_pkg::NVM_OP_READ, ad[s], 16'h0, 2'h3);
      bus(1'b0, `NVM_REG_RDATA, 32'h0, 1'b1, {16'h0, dat[s]});
    end
  endtask
  initial
  begin
    rv = $urandom(32'h5abea25f);
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    bus(1'b0, `NVM_REG_CTRL, 32'h0, 1'b1, 32'h30);
    bus(1'b0, `NVM_REG_STATUS, 32'h0, 1'b1, 32'h0);
    bus(1'b1, 3'h7, 32'hffffffff, 1'b0, 32'h0);
    bus(1'b0, 3'h7, 32'h0, 1'b1, 32'h0);
    // only the enabled byte of the address merges
    bus(1'b1, `NVM_REG_ADDR, 32'h00012345, 1'b0, 32'h0);
    be_sel = 4'h2;
    bus(1'b1, `NVM_REG_ADDR, 32'hffffffff, 1'b0, 32'h0);
    be_sel = 4'hf;
    bus(1'b0, `NVM_REG_ADDR, 32'h0, 1'b1, 32'h0001ff45);
    $display("test registers done");
    for (int s = 0; s < 8; s++)
    begin
      ad[s] = {s[2:0], 14'($urandom_range(16383, 1))};
      dat[s] = 16'h0;
    end
    sweep(8'h00);
    $display("test sectors done");
    nd = 16'($urandom());
    mem_op(nvm_pkg::NVM_OP_WRITE, ad[2], nd, 2'h1);
    dat[2][7:0] = nd[7:0];
    // second start stalls on the bus until the first read is finished
    bus(1'b1, `NVM_REG_CTRL, {26'h0, 2'h3, 1'b0, nvm_pkg::NVM_OP_READ, 1'b1}, 1'b0, 32'h0);
    mem_op(nvm_pkg::NVM_OP_READ, ad[2], 16'h0, 2'h3);
    bus(1'b0, `NVM_REG_RDATA, 32'h0, 1'b1, {16'h0, dat[2]});
    $display("test lanes done");
    protect(8'h18);
    sweep(8'h18);
    protect(8'h00);
    sweep(8'h00);
    $display("test protect done");
    close_out();
  end
endmodule
